// >>> pkg/wasd_pkg.sv
// Package: constants and types of the auto-shutdown source block
// How it works
// (RQ1) Each timer shutdown enable (bits 6, 5, 4) lets that timer's postscaled output trigger shutdown, and a clear enable ignores it.
// (RQ2) With the comparator B enable (bit 2) set, an active comparator B output forces shutdown, otherwise it has no effect.
// (RQ3) With the comparator A enable (bit 1) set, an active comparator A output forces shutdown, otherwise it has no effect.
// (RQ4) With the pin enable (bit 0) set, an active shutdown pin level forces shutdown, otherwise the pin is ignored.
// (RQ5) After the shutdown condition clears, outputs stay shut down until the next rising edge of the input waveform.
// (RQ6) The shutdown request is the OR of all enabled active sources.
// (RQ7) During shutdown each pair follows its two-bit state field: 01 tri-states, 00 drives the inactive level after the dead band.
// (RQ8) Auto-restart decides whether shutdown ends by itself when sources go idle or only when software clears it.
package wasd_pkg;
	localparam logic [7:0] ADDR_ENABLES = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
	localparam int BIT_PIN = 0;
	localparam int BIT_CMP_A = 1;
	localparam int BIT_CMP_B = 2;
	localparam int BIT_TMR_A = 4;
	localparam int BIT_TMR_B = 5;
	localparam int BIT_TMR_C = 6;
	localparam logic [7:0] ENABLES_WMASK = 8'h77;
	localparam logic [7:0] ENABLES_ONES = 8'h88;
	localparam logic [7:0] ENABLES_RESET = 8'h00;
	// Control: [0] shutdown flag, [1] auto restart, [3:2] pair AC, [5:4] pair BD
	localparam int CTL_SHUT = 0;
	localparam int CTL_REN = 1;
	localparam int CTL_AC_LO = 2;
	localparam int CTL_BD_LO = 4;
	localparam logic [1:0] SDS_TRISTATE = 2'b01;
	localparam logic [1:0] SDS_INACTIVE = 2'b00;
	localparam logic [1:0] SDS_DRIVE0 = 2'b10;
	localparam logic [1:0] SDS_DRIVE1 = 2'b11;
	localparam int DEADBAND_NS = 20;
	localparam int CLK_NS = 5;
	localparam logic [3:0] DEADBAND_CYC = 4'((DEADBAND_NS + CLK_NS - 1) / CLK_NS);
	localparam int IRQ_ENTER = 0;
	localparam int IRQ_RESUME = 1;
	localparam logic [1:0] AXI_OKAY = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;
	typedef struct packed {
		logic [2:0] timer;
		logic [1:0] cmp;
		logic pin;
	} wasd_src_t;
	typedef struct packed {
		logic [3:0] level;
		logic [3:0] oe;
	} wasd_out_t;
endpackage : wasd_pkg

// >>> src/wasd_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module wasd_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} wasd_sync_st_t;
	wasd_sync_st_t st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		st_next.s1 = asyncIn;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.q[i] = st_reg.s3[i];
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign syncOut = st_reg.q;
endmodule : wasd_sync
`default_nettype wire

// >>> src/wasd_top.sv
// Auto-shutdown source selection with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module wasd_top (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire wasd_pkg::wasd_src_t srcIn,
	input wire logic waveIn,
	input wire logic [3:0] driveLevel,
	input wire logic [3:0] inactiveLevel,
	output wasd_pkg::wasd_out_t pairOut,
	output logic shutdownActive,
	output logic irq
);
	import wasd_pkg::*;

	typedef struct packed {
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [7:0] enables;
		logic autoRestart;
		logic [1:0] acState;
		logic [1:0] bdState;
		logic shut;
		logic waveLast;
		logic [3:0] deadCount;
		logic [1:0] irqStatus;
		logic [1:0] irqEnable;
		wasd_out_t outs;
	} wasd_st_t;

	wasd_st_t st_reg, st_next;
	wasd_src_t srcSync;
	logic waveSync;
	logic request;
	logic [1:0] irqEvent;
	logic wrFire;
	logic swClearShut;
	logic swSetShut;

	//--------------------------------------------------
	// Input synchronisers
	//--------------------------------------------------
	wasd_sync #(.WIDTH(7)) u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn({srcIn, waveIn}),
		.syncOut({srcSync, waveSync})
	);

	//--------------------------------------------------
	// Source combine
	//--------------------------------------------------
	always_comb begin
		request = 1'b0;
		if (st_reg.enables[BIT_TMR_A] && srcSync.timer[0]) request = 1'b1; // RQ1
		if (st_reg.enables[BIT_TMR_B] && srcSync.timer[1]) request = 1'b1; // RQ1
		if (st_reg.enables[BIT_TMR_C] && srcSync.timer[2]) request = 1'b1; // RQ1
		if (st_reg.enables[BIT_CMP_B] && srcSync.cmp[1]) request = 1'b1; // RQ2
		if (st_reg.enables[BIT_CMP_A] && srcSync.cmp[0]) request = 1'b1; // RQ3
		if (st_reg.enables[BIT_PIN] && srcSync.pin) request = 1'b1; // RQ4 RQ6
	end

	assign wrFire = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
	assign swClearShut = wrFire && st_reg.awAddr == ADDR_CONTROL
		&& st_reg.wStrb[0] && !st_reg.wData[CTL_SHUT];
	assign swSetShut = wrFire && st_reg.awAddr == ADDR_CONTROL
		&& st_reg.wStrb[0] && st_reg.wData[CTL_SHUT];

	//--------------------------------------------------
	// Next state
	//--------------------------------------------------
	always_comb begin
		logic [1:0] sel;
		sel = 2'b00;
		st_next = st_reg;
		irqEvent = 2'b00;
		st_next.waveLast = waveSync;
		// Bus channels
		if (s_axi_awvalid && !st_reg.awHeld) begin
			st_next.awHeld = 1'b1;
			st_next.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.wHeld) begin
			st_next.wHeld = 1'b1;
			st_next.wData = s_axi_wdata;
			st_next.wStrb = s_axi_wstrb;
		end
		if (st_reg.bValid && s_axi_bready) st_next.bValid = 1'b0;
		if (wrFire) begin
			st_next.awHeld = 1'b0;
			st_next.wHeld = 1'b0;
			st_next.bValid = 1'b1;
			st_next.bResp = AXI_OKAY;
			if (st_reg.awAddr == ADDR_ENABLES) begin
				if (st_reg.wStrb[0])
					st_next.enables = st_reg.wData[7:0] & ENABLES_WMASK;
			end else if (st_reg.awAddr == ADDR_CONTROL) begin
				if (st_reg.wStrb[0]) begin
					st_next.autoRestart = st_reg.wData[CTL_REN];
					st_next.acState = st_reg.wData[CTL_AC_LO +: 2];
					st_next.bdState = st_reg.wData[CTL_BD_LO +: 2];
				end
			end else if (st_reg.awAddr == ADDR_IRQ_CLEAR) begin
				if (st_reg.wStrb[0])
					st_next.irqStatus = st_reg.irqStatus & ~st_reg.wData[1:0];
			end else if (st_reg.awAddr == ADDR_IRQ_ENABLE) begin
				if (st_reg.wStrb[0]) st_next.irqEnable = st_reg.wData[1:0];
			end else if (st_reg.awAddr != ADDR_STATUS) begin
				st_next.bResp = AXI_SLVERR;
			end
		end
		if (st_reg.rValid && s_axi_rready) st_next.rValid = 1'b0;
		if (s_axi_arvalid && !st_reg.rValid) begin
			st_next.rValid = 1'b1;
			st_next.rResp = AXI_OKAY;
			st_next.rData = '0;
			if (s_axi_araddr == ADDR_ENABLES) begin
				st_next.rData[7:0] = st_reg.enables | ENABLES_ONES;
			end else if (s_axi_araddr == ADDR_CONTROL) begin
				st_next.rData[CTL_SHUT] = st_reg.shut;
				st_next.rData[CTL_REN] = st_reg.autoRestart;
				st_next.rData[CTL_AC_LO +: 2] = st_reg.acState;
				st_next.rData[CTL_BD_LO +: 2] = st_reg.bdState;
			end else if (s_axi_araddr == ADDR_STATUS) begin
				st_next.rData[1:0] = st_reg.irqStatus;
			end else if (s_axi_araddr == ADDR_IRQ_ENABLE) begin
				st_next.rData[1:0] = st_reg.irqEnable;
			end else if (s_axi_araddr != ADDR_IRQ_CLEAR) begin
				st_next.rResp = AXI_SLVERR;
			end
		end
		// Shutdown flag: request wins over a software clear
		if (request || swSetShut) begin
			if (!st_reg.shut) irqEvent[IRQ_ENTER] = 1'b1;
			st_next.shut = 1'b1;
		end else if (st_reg.shut && (st_reg.autoRestart || swClearShut)) begin
			st_next.shut = 1'b0; // RQ8
		end
		// Dead band runs from entry, then rests at one to hold shutdown
		// until a rising input edge once the flag is gone
		if (!shutdownActive && st_next.shut) begin
			st_next.deadCount = DEADBAND_CYC;
		end else if (!st_reg.shut && !st_next.shut && shutdownActive
			&& waveSync && !st_reg.waveLast) begin
			st_next.deadCount = '0; // RQ5
			irqEvent[IRQ_RESUME] = 1'b1;
		end else if (st_reg.deadCount > 4'd1) begin
			st_next.deadCount = st_reg.deadCount - 4'd1;
		end
		// Pair outputs: A and C use the AC field, B and D the BD field
		for (int i = 0; i < 4; i++) begin
			sel = (i % 2 == 0) ? st_reg.acState : st_reg.bdState;
			if (!shutdownActive) begin
				st_next.outs.oe[i] = 1'b1;
				st_next.outs.level[i] = driveLevel[i];
			end else if (sel == SDS_TRISTATE) begin
				st_next.outs.oe[i] = 1'b0; // RQ7
				st_next.outs.level[i] = 1'b0;
			end else if (sel == SDS_INACTIVE) begin
				// Holds the last level until the dead band elapses
				st_next.outs.oe[i] = 1'b1;
				if (st_reg.deadCount <= 4'd1)
					st_next.outs.level[i] = inactiveLevel[i]; // RQ7
			end else begin
				st_next.outs.oe[i] = 1'b1;
				st_next.outs.level[i] = sel[0];
			end
		end
		// Set beats clear for the sticky status
		st_next.irqStatus = st_next.irqStatus | irqEvent;
	end

	// Shutdown holds from the flag until the resume edge
	assign shutdownActive = st_reg.shut || st_reg.deadCount != 4'd0;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.enables <= ENABLES_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	//--------------------------------------------------
	// Ports
	//--------------------------------------------------
	assign s_axi_awready = !st_reg.awHeld;
	assign s_axi_wready = !st_reg.wHeld;
	assign s_axi_bvalid = st_reg.bValid;
	assign s_axi_bresp = st_reg.bResp;
	assign s_axi_arready = !st_reg.rValid;
	assign s_axi_rvalid = st_reg.rValid;
	assign s_axi_rdata = st_reg.rData;
	assign s_axi_rresp = st_reg.rResp;
	assign pairOut = st_reg.outs;
	assign irq = |(st_reg.irqStatus & st_reg.irqEnable);

	//--------------------------------------------------
	// Assertions
	//--------------------------------------------------
	property p_timer_a;
		@(posedge mclk) disable iff (sys_rst)
		(st_reg.enables[BIT_TMR_A] && srcSync.timer[0]) |=> st_reg.shut;
	endproperty
	a_timer_a: assert property (p_timer_a) else $error("timer a ignored"); // RQ1

	property p_timer_off;
		@(posedge mclk) disable iff (sys_rst)
		(!st_reg.enables[BIT_TMR_C] && srcSync.timer[2] && !request
		 && !swSetShut && !st_reg.shut) |=> !st_reg.shut;
	endproperty
	a_timer_off: assert property (p_timer_off) else $error("timer c leaked"); // RQ1

	property p_cmp_b;
		@(posedge mclk) disable iff (sys_rst)
		(st_reg.enables[BIT_CMP_B] && srcSync.cmp[1]) |-> request;
	endproperty
	a_cmp_b: assert property (p_cmp_b) else $error("comparator b ignored"); // RQ2

	property p_cmp_a;
		@(posedge mclk) disable iff (sys_rst)
		(st_reg.enables[BIT_CMP_A] && srcSync.cmp[0]) |=> shutdownActive;
	endproperty
	a_cmp_a: assert property (p_cmp_a) else $error("comparator a ignored"); // RQ3

	property p_pin;
		@(posedge mclk) disable iff (sys_rst)
		(st_reg.enables[BIT_PIN] && srcSync.pin) |=> ##1 st_reg.deadCount != 0;
	endproperty
	a_pin: assert property (p_pin) else $error("pin ignored"); // RQ4

	property p_hold;
		@(posedge mclk) disable iff (sys_rst)
		($fell(st_reg.shut) && !(waveSync && !st_reg.waveLast)) |-> shutdownActive;
	endproperty
	a_hold: assert property (p_hold) else $error("early resume"); // RQ5

	property p_or;
		@(posedge mclk) disable iff (sys_rst)
		(request == |({srcSync.timer, srcSync.cmp, srcSync.pin}
		 & {st_reg.enables[6:4], st_reg.enables[2:0]}));
	endproperty
	a_or: assert property (p_or) else $error("request not an OR"); // RQ6

	property p_tri;
		@(posedge mclk) disable iff (sys_rst)
		(shutdownActive && st_reg.acState == SDS_TRISTATE) ##1 shutdownActive
		|-> !pairOut.oe[0];
	endproperty
	a_tri: assert property (p_tri) else $error("pair ac not tristated"); // RQ7

	property p_restart;
		@(posedge mclk) disable iff (sys_rst)
		(st_reg.shut && !request && !swSetShut && !st_reg.autoRestart
		 && !swClearShut) |=> st_reg.shut;
	endproperty
	a_restart: assert property (p_restart) else $error("left shutdown alone"); // RQ8
endmodule : wasd_top
`default_nettype wire

// >>> testbench/wasd_src_model.sv
// Behavioural model of the shutdown sources and the input waveform
`timescale 1ns/100ps
`default_nettype none
module wasd_src_model (
	input wire logic mclk,
	input wire logic [5:0] srcCmd,
	input wire logic waveRun,
	output wasd_pkg::wasd_src_t srcIn,
	output logic waveIn
);
	import wasd_pkg::*;
	logic [2:0] phase;
	initial begin
		srcIn = '0;
		phase = '0;
	end
	// Sources move just after the edge, as timer and comparator logic does
	always @(posedge mclk) begin
		srcIn <= wasd_src_t'(srcCmd);
		phase <= waveRun ? phase + 3'h1 : 3'h0;
	end
	// Stopped waveform rests low so no rising edge can slip in
	assign waveIn = phase[2];
endmodule : wasd_src_model
`default_nettype wire

// >>> testbench/tb_waveform_autoshutdown_sources.sv
// Self-checking bench of the auto-shutdown source block
`timescale 1ns/100ps
`default_nettype none
module tb_waveform_autoshutdown_sources;
	import wasd_pkg::*;
	localparam logic [3:0] DRV = 4'ha;
	localparam logic [3:0] INACT = 4'h5;
	logic mclk = 1'b0;
	logic sysRst = 1'b1;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
	logic [31:0] wData = 32'h0;
	logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
	logic awReady, wReady, bValid, arReady, rValid, shutAct, irq, waveIn;
	logic [1:0] bResp, rResp, resp;
	logic [31:0] rData, got;
	logic [5:0] srcCmd = 6'h00;
	logic waveRun = 1'b0;
	wasd_src_t srcIn;
	wasd_out_t pairOut;
	int mismatches = 0;
	int checks = 0;

	always #2.5 mclk = ~mclk;

	wasd_top u_dut (.mclk(mclk), .sys_rst(sysRst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .srcIn(srcIn),
		.waveIn(waveIn), .driveLevel(DRV), .inactiveLevel(INACT),
		.pairOut(pairOut), .shutdownActive(shutAct), .irq(irq));

	wasd_src_model u_src (.mclk(mclk), .srcCmd(srcCmd),
		.waveRun(waveRun), .srcIn(srcIn), .waveIn(waveIn));

	// ----------------------------------------
	// Bus cycles and comparison
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(posedge mclk);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
		end while (!bValid);
		resp = bResp;
		bReady <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(posedge mclk);
			if (arValid && arReady) arValid <= 1'b0;
		end while (!rValid);
		got = rData;
		resp = rResp;
		rReady <= 1'b0;
	endtask : rd

	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic tally_and_finish;
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic regs_test;
		rd(ADDR_ENABLES);
		chk("enables reset", got, 32'h88);
		rd(8'h20);
		chk("unmapped read", 32'(resp), 32'(AXI_SLVERR));
		wr(8'h20, 32'h1);
		chk("unmapped write", 32'(resp), 32'(AXI_SLVERR));
		wr(ADDR_ENABLES, 32'hff);
		rd(ADDR_ENABLES);
		chk("enables rw", got, 32'hff);
		rd(ADDR_IRQ_CLEAR);
		chk("clear reads", got, 32'h0);
	endtask : regs_test

	// Each source alone, first masked with all others enabled
	task automatic source_test;
		int s;
		wr(ADDR_CONTROL, 32'h06);
		for (int i = 0; i < 7; i++) begin
			if (i == 3) continue;
			s = (i < 3) ? i : i - 1;
			wr(ADDR_ENABLES, 32'h77 & ~(32'h1 << i));
			srcCmd <= 6'(1 << s);
			cyc(10);
			chk("masked source", 32'(shutAct), 32'h0);
			wr(ADDR_ENABLES, 32'h1 << i);
			cyc(10);
			chk("enabled source", 32'(shutAct), 32'h1);
			chk("pair oe", 32'(pairOut.oe), 32'ha);
			chk("pair bd", 32'(pairOut.level & 4'ha), 32'(INACT & 4'ha));
			srcCmd <= 6'h00;
			waveRun <= 1'b1;
			cyc(30);
			waveRun <= 1'b0;
			chk("auto resumed", 32'(shutAct), 32'h0);
			chk("normal out", 32'(pairOut), 32'({DRV, 4'hf}));
		end
	endtask : source_test

	task automatic restart_test;
		wr(ADDR_CONTROL, 32'h00);
		wr(ADDR_ENABLES, 32'h01);
		srcCmd <= 6'h01;
		cyc(10);
		srcCmd <= 6'h00;
		cyc(20);
		chk("held no restart", 32'(shutAct), 32'h1);
		chk("inactive out", 32'(pairOut), 32'({INACT, 4'hf}));
		wr(ADDR_CONTROL, 32'h00);
		cyc(20);
		chk("held until edge", 32'(shutAct), 32'h1);
		waveRun <= 1'b1;
		cyc(20);
		waveRun <= 1'b0;
		chk("resumed on edge", 32'(shutAct), 32'h0);
	endtask : restart_test

	task automatic irq_test;
		wr(ADDR_IRQ_ENABLE, 32'h1);
		wr(ADDR_IRQ_CLEAR, 32'h3);
		chk("irq cleared", 32'(irq), 32'h0);
		wr(ADDR_CONTROL, 32'h02);
		srcCmd <= 6'h01;
		cyc(10);
		chk("irq raised", 32'(irq), 32'h1);
		rd(ADDR_STATUS);
		chk("status entered", got & 32'h1, 32'h1);
		wr(ADDR_IRQ_ENABLE, 32'h0);
		chk("irq masked", 32'(irq), 32'h0);
		wr(ADDR_IRQ_ENABLE, 32'h1);
		wr(ADDR_IRQ_CLEAR, 32'h1);
		chk("irq cleared again", 32'(irq), 32'h0);
		srcCmd <= 6'h00;
	endtask : irq_test

	// Software forced shutdown with both driven states
	task automatic drive_test;
		wr(ADDR_ENABLES, 32'h00);
		waveRun <= 1'b1;
		cyc(20);
		waveRun <= 1'b0;
		chk("idle before force", 32'(shutAct), 32'h0);
		wr(ADDR_IRQ_CLEAR, 32'h3);
		wr(ADDR_CONTROL, 32'h2d);
		cyc(10);
		chk("forced shutdown", 32'(shutAct), 32'h1);
		chk("driven states", 32'(pairOut), 32'h5f);
		rd(ADDR_CONTROL);
		chk("control readback", got, 32'h2d);
		wr(ADDR_CONTROL, 32'h2c);
		cyc(10);
		chk("held after clear", 32'(shutAct), 32'h1);
		waveRun <= 1'b1;
		cyc(20);
		waveRun <= 1'b0;
		chk("resumed after force", 32'(shutAct), 32'h0);
		rd(ADDR_STATUS);
		chk("status both events", got, 32'h3);
	endtask : drive_test

	initial begin
		cyc(6);
		sysRst <= 1'b0;
		regs_test();
		source_test();
		restart_test();
		irq_test();
		drive_test();
		tally_and_finish();
	end

	// Whole run needs well under 3000 cycles
	initial begin
		cyc(20000);
		mismatches++;
		tally_and_finish();
	end
endmodule : tb_waveform_autoshutdown_sources
`default_nettype wire
